// ===== rtl/mbag_guard.sv
`timescale 1ns/1ps
// Contract
// - Memory partition fixed, never software changeable
// - Reset loads defined default access attributes
// - Segment pointer writes only in system mode
// - Mapper configuration registers system mode only
// - System mode reaches peripheral control registers
// - User mode default: core registers only
// - User peripheral access when mapper grants it
// - Peripheral grants and the user segment window are configurable
// - Attribute updates restricted to privileged mode
// - Nonvolatile read level trim control provided
module mbag_guard #(
  parameter int NUM_COMP = mbag_pkg::NUM_COMP
) (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire mbag_pkg::mbag_req_t req,
  output mbag_pkg::mbag_fwd_t      fwd,
  output logic [15:0]              rdata,
  output logic                     rvalid,
  output logic                     violation,
  output logic [15:0]              seg_table_ptr,
  output logic [15:0]              seg_base,
  output logic [15:0]              seg_limit,
  output logic [3:0]               nvm_read_trim
);

  // ****************************************
  // Access classification
  // ****************************************
  logic [NUM_COMP-1:0] user_grant;
  logic [NUM_COMP-1:0] fw_grant;
  logic                in_creg;
  logic                in_core;
  logic                in_map;
  logic                in_per;
  logic                in_fw_area;
  logic                in_seg;
  logic [2:0]          comp_idx;
  logic                allowed;
  logic                map_wr;

  // Component index of a peripheral register address
  function automatic logic [2:0] comp_of(input logic [15:0] a);
    logic [15:0] off;
    off = a - mbag_pkg::CREG_PER_BASE;
    return off[mbag_pkg::COMP_SHIFT +: 3];
  endfunction

  // Region decode
  always_comb begin
    in_creg    = req.addr >= mbag_pkg::CREG_BASE;
    in_core    = in_creg && (req.addr < mbag_pkg::CREG_CORE_END);
    in_map     = (req.addr >= mbag_pkg::CREG_MAP_BASE) && (req.addr < mbag_pkg::CREG_MAP_END);
    in_per     = req.addr >= mbag_pkg::CREG_PER_BASE;
    // Partition boundary is a constant; no register can move it
    in_fw_area = req.addr < mbag_pkg::FW_AREA_END;
    in_seg     = (req.addr >= seg_base) && (req.addr < seg_limit);
    comp_idx   = comp_of(req.addr);
  end

  // Rights decision; everything not listed is hard wired
  always_comb begin
    allowed = 1'b0;
    if (in_core) begin
      allowed = 1'b1;
    end else if (in_map) begin
      allowed = (req.mode == mbag_pkg::MBAG_MODE_SYSTEM);
    end else if (in_per) begin
      case (req.mode)
        mbag_pkg::MBAG_MODE_SYSTEM:   allowed = 1'b1;
        mbag_pkg::MBAG_MODE_FIRMWARE: allowed = fw_grant[comp_idx];
        mbag_pkg::MBAG_MODE_USER:     allowed = user_grant[comp_idx];
        default:                      allowed = 1'b0;
      endcase
    end else if (in_creg) begin
      allowed = 1'b0; // Unmapped control space
    end else if (in_fw_area) begin
      allowed = (req.mode != mbag_pkg::MBAG_MODE_USER);
    end else begin
      // Segments start empty, so user memory is shut until set up
      allowed = (req.mode != mbag_pkg::MBAG_MODE_USER) || in_seg;
    end
  end

  assign map_wr = req.valid && req.write && in_map && allowed;

  // ****************************************
  // Segment mapper configuration
  // ****************************************
  // Pointer and segment window, system mode writes only
  always_ff @(posedge clock) begin
    if (srst) begin
      seg_table_ptr <= mbag_pkg::RST_MAP_PTR;
      seg_base      <= mbag_pkg::RST_SEG_BASE;
      seg_limit     <= mbag_pkg::RST_SEG_LIMIT;
    end else if (map_wr) begin
      if (req.addr == mbag_pkg::CREG_MAP_PTR) begin
        seg_table_ptr <= req.wdata;
      end else if (req.addr == mbag_pkg::CREG_MAP_SEGB) begin
        seg_base <= req.wdata;
      end else if (req.addr == mbag_pkg::CREG_MAP_SEGL) begin
        seg_limit <= req.wdata;
      end
    end
  end

  // Grant masks: configurable access attributes, as is the segment window
  always_ff @(posedge clock) begin
    if (srst) begin
      user_grant <= NUM_COMP'(mbag_pkg::RST_GRANT);
      fw_grant   <= NUM_COMP'(mbag_pkg::RST_GRANT);
    end else if (map_wr) begin
      if (req.addr == mbag_pkg::CREG_MAP_USR) begin
        user_grant <= req.wdata[NUM_COMP-1:0];
      end else if (req.addr == mbag_pkg::CREG_MAP_FW) begin
        fw_grant <= req.wdata[NUM_COMP-1:0];
      end
    end
  end

  // Nonvolatile read trim; mid-scale default suits fresh cells
  always_ff @(posedge clock) begin
    if (srst) begin
      nvm_read_trim <= mbag_pkg::RST_NVM_TRIM;
    end else if (map_wr && (req.addr == mbag_pkg::CREG_MAP_NVM)) begin
      nvm_read_trim <= req.wdata[3:0];
    end
  end

  // ****************************************
  // Forwarding, readback and violation
  // ****************************************
  // Denied requests never reach the target
  always_ff @(posedge clock) begin
    if (srst) begin
      fwd <= '0;
    end else begin
      fwd.pass  <= req.valid && allowed && !in_map;
      fwd.write <= req.write;
      fwd.addr  <= req.addr;
      fwd.wdata <= req.wdata;
    end
  end

  // Mapper readback; rvalid only for permitted reads, rdata loads for any address
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.valid && !req.write && in_map && allowed;
      if (req.addr == mbag_pkg::CREG_MAP_PTR) begin
        rdata <= seg_table_ptr;
      end else if (req.addr == mbag_pkg::CREG_MAP_USR) begin
        rdata <= 16'(user_grant);
      end else if (req.addr == mbag_pkg::CREG_MAP_FW) begin
        rdata <= 16'(fw_grant);
      end else if (req.addr == mbag_pkg::CREG_MAP_SEGB) begin
        rdata <= seg_base;
      end else if (req.addr == mbag_pkg::CREG_MAP_SEGL) begin
        rdata <= seg_limit;
      end else if (req.addr == mbag_pkg::CREG_MAP_NVM) begin
        rdata <= {12'h000, nvm_read_trim};
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  // One-cycle violation pulse to the core
  always_ff @(posedge clock) begin
    if (srst) begin
      violation <= 1'b0;
    end else begin
      violation <= req.valid && !allowed;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence user_ptr_write_s;
    req.valid && req.write && (req.mode != mbag_pkg::MBAG_MODE_SYSTEM)
      && (req.addr == mbag_pkg::CREG_MAP_PTR);
  endsequence

  ptr_keep_a: assert property (@(posedge clock) disable iff (srst)
    user_ptr_write_s |=> $stable(seg_table_ptr))
    else $error("pointer changed outside system mode");

  ptr_load_a: assert property (@(posedge clock) disable iff (srst)
    (req.valid && req.write && req.mode == mbag_pkg::MBAG_MODE_SYSTEM
      && req.addr == mbag_pkg::CREG_MAP_PTR) |=> seg_table_ptr == $past(req.wdata))
    else $error("system pointer write lost");

  map_deny_a: assert property (@(posedge clock) disable iff (srst)
    (req.valid && in_map && req.mode != mbag_pkg::MBAG_MODE_SYSTEM) |=> violation && !rvalid)
    else $error("mapper access outside system mode");

  sys_per_a: assert property (@(posedge clock) disable iff (srst)
    (req.valid && in_per && req.mode == mbag_pkg::MBAG_MODE_SYSTEM) |=> fwd.pass)
    else $error("system peripheral access blocked");

  user_core_a: assert property (@(posedge clock) disable iff (srst)
    (req.valid && in_core) |=> fwd.pass && !violation)
    else $error("core register access blocked");

  user_grant_a: assert property (@(posedge clock) disable iff (srst)
    (req.valid && in_per && req.mode == mbag_pkg::MBAG_MODE_USER)
      |=> fwd.pass == $past(user_grant[comp_idx]))
    else $error("user peripheral grant misapplied");

  reset_dflt_a: assert property (@(posedge clock)
    srst |=> (user_grant == mbag_pkg::RST_GRANT) && (seg_limit == mbag_pkg::RST_SEG_LIMIT)
      && (nvm_read_trim == mbag_pkg::RST_NVM_TRIM))
    else $error("reset defaults not loaded");

  fw_part_a: assert property (@(posedge clock) disable iff (srst)
    (req.valid && req.mode == mbag_pkg::MBAG_MODE_USER && in_fw_area)
      |=> violation && !fwd.pass)
    else $error("user reached firmware partition");

  viol_block_a: assert property (@(posedge clock) disable iff (srst)
    violation |-> !fwd.pass)
    else $error("violating access forwarded");

endmodule

// ===== rtl/mbag_pkg.sv
package mbag_pkg;

  // ****************************************
  // Privilege modes
  // ****************************************
  typedef enum logic [1:0] {
    MBAG_MODE_SYSTEM   = 2'h0,
    MBAG_MODE_FIRMWARE = 2'h1,
    MBAG_MODE_USER     = 2'h2
  } mbag_mode_t;

  // ****************************************
  // Address map and field layout
  // ****************************************
  localparam int         ADDR_W         = 16;
  localparam int         DATA_W         = 16;
  localparam int         NUM_COMP       = 8;
  // Fixed partition: firmware area below this bound
  localparam logic [15:0] FW_AREA_END   = 16'h2000;
  // Control register window
  localparam logic [15:0] CREG_BASE     = 16'hff00;
  // Core registers open to every mode
  localparam logic [15:0] CREG_CORE_END = 16'hff40;
  // Segment mapper configuration registers
  localparam logic [15:0] CREG_MAP_BASE = 16'hff40;
  localparam logic [15:0] CREG_MAP_PTR  = 16'hff40;
  localparam logic [15:0] CREG_MAP_USR  = 16'hff41;
  localparam logic [15:0] CREG_MAP_FW   = 16'hff42;
  localparam logic [15:0] CREG_MAP_SEGB = 16'hff43;
  localparam logic [15:0] CREG_MAP_SEGL = 16'hff44;
  localparam logic [15:0] CREG_MAP_NVM  = 16'hff45;
  localparam logic [15:0] CREG_MAP_END  = 16'hff48;
  // Peripheral component registers, 16 addresses per component
  localparam logic [15:0] CREG_PER_BASE = 16'hff80;
  localparam int         COMP_SHIFT     = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] RST_MAP_PTR   = 16'h0000;
  localparam logic [7:0]  RST_GRANT     = 8'h00;
  localparam logic [15:0] RST_SEG_BASE  = 16'h0000;
  localparam logic [15:0] RST_SEG_LIMIT = 16'h0000;
  localparam logic [3:0]  RST_NVM_TRIM  = 4'h8;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic              valid;
    logic              write;
    mbag_mode_t        mode;
    logic [15:0]       addr;
    logic [15:0]       wdata;
  } mbag_req_t;

  typedef struct packed {
    logic              pass;
    logic              write;
    logic [15:0]       addr;
    logic [15:0]       wdata;
  } mbag_fwd_t;

endpackage

// ===== test/mbag_core_model.sv
`timescale 1ns/1ps
// ****************************************
// Core side request source
// ****************************************
module mbag_core_model (
  input  wire logic           clock,
  output mbag_pkg::mbag_req_t req
);
  // Idle from time zero, nothing requested
  initial begin
    req = '0;
  end

  // One access: drive after an edge, hold through the taking edge, then release
  // Returns just after the taking edge, while the one-cycle answer still stands
  task automatic issue(input logic w, input mbag_pkg::mbag_mode_t m,
                       input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    req = {1'b1, w, m, a, d};
    @(posedge clock);
    #1;
    // Released fields flip so a stale address never looks like a fresh one
    req.valid = 1'b0;
    req.addr  = ~a;
    req.wdata = ~d;
  endtask
endmodule

// ===== test/mode_based_access_guard_tb_top.sv
`timescale 1ns/1ps
module mode_based_access_guard_tb_top;
  localparam mbag_pkg::mbag_mode_t SYS = mbag_pkg::MBAG_MODE_SYSTEM;
  localparam mbag_pkg::mbag_mode_t FW  = mbag_pkg::MBAG_MODE_FIRMWARE;
  localparam mbag_pkg::mbag_mode_t USR = mbag_pkg::MBAG_MODE_USER;
  // Expected answer codes: {pass, violation, rvalid}
  localparam logic [2:0] PS = 3'h4;
  localparam logic [2:0] VI = 3'h2;
  localparam logic [2:0] RD = 3'h1;
  localparam logic [2:0] NO = 3'h0;
  logic                clock = 1'b0;
  logic                srst  = 1'b1;
  mbag_pkg::mbag_req_t req;
  mbag_pkg::mbag_fwd_t fwd;
  logic [15:0]         rdata;
  logic                rvalid;
  logic                violation;
  logic [15:0]         seg_table_ptr;
  logic [15:0]         seg_base;
  logic [15:0]         seg_limit;
  logic [3:0]          nvm_read_trim;
  int                  n_errors = 0;
  int                  checks = 0;

  // ****************************************
  // Clock and instances
  // ****************************************
  always #12.5 clock = ~clock;

  mbag_core_model i_core (.clock(clock), .req(req));

  mbag_guard i_dut (.clock(clock), .srst(srst), .req(req), .fwd(fwd), .rdata(rdata),
    .rvalid(rvalid), .violation(violation), .seg_table_ptr(seg_table_ptr),
    .seg_base(seg_base), .seg_limit(seg_limit), .nvm_read_trim(nvm_read_trim));

  // ****************************************
  // Compare helpers
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Answers stand one cycle, so they are judged right where the model returns
  task automatic acc(input logic w, input mbag_pkg::mbag_mode_t m, input logic [15:0] a,
                     input logic [15:0] d, input logic [2:0] e);
    i_core.issue(w, m, a, d);
    chk({13'h0, fwd.pass, violation, rvalid}, {13'h0, e});
    if (e == PS) begin
      chk(fwd.addr, a);
      chk(fwd.wdata, d);
      chk({15'h0, fwd.write}, {15'h0, w});
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_defaults;
    chk(seg_table_ptr, mbag_pkg::RST_MAP_PTR);
    chk(seg_base, mbag_pkg::RST_SEG_BASE);
    chk(seg_limit, mbag_pkg::RST_SEG_LIMIT);
    chk({12'h0, nvm_read_trim}, {12'h0, mbag_pkg::RST_NVM_TRIM});
    acc(1'b0, SYS, mbag_pkg::CREG_MAP_USR, 16'h0, RD);
    chk(rdata, {8'h0, mbag_pkg::RST_GRANT});
  endtask

  task automatic t_pointer;
    acc(1'b1, USR, mbag_pkg::CREG_MAP_PTR, 16'h1234, VI);
    acc(1'b1, FW, mbag_pkg::CREG_MAP_PTR, 16'h1234, VI);
    chk(seg_table_ptr, 16'h0);
    acc(1'b1, SYS, mbag_pkg::CREG_MAP_PTR, 16'h1234, NO);
    chk(seg_table_ptr, 16'h1234);
    acc(1'b0, USR, mbag_pkg::CREG_MAP_PTR, 16'h0, VI);
    acc(1'b0, SYS, mbag_pkg::CREG_MAP_PTR, 16'h0, RD);
    chk(rdata, 16'h1234);
  endtask

  task automatic t_periph;
    acc(1'b0, SYS, mbag_pkg::CREG_PER_BASE, 16'h0, PS);
    acc(1'b0, USR, 16'hff3f, 16'h0, PS);
    acc(1'b0, USR, 16'hff48, 16'h0, VI);
    acc(1'b1, SYS, mbag_pkg::CREG_MAP_USR, 16'h0081, NO);
    // Grant 0x81 opens only the first and last component
    for (int i = 0; i < 8; i++) begin
      acc(1'b0, USR, 16'hff80 + 16'(i * 16), 16'h0, (i == 0 || i == 7) ? PS : VI);
    end
    acc(1'b1, USR, mbag_pkg::CREG_MAP_USR, 16'h00ff, VI);
    acc(1'b0, USR, 16'hff90, 16'h0, VI);
    acc(1'b1, SYS, mbag_pkg::CREG_MAP_FW, 16'h0002, NO);
    acc(1'b1, FW, 16'hff9f, 16'h55aa, PS);
    acc(1'b1, FW, 16'hff80, 16'h55aa, VI);
  endtask

  task automatic t_memory;
    acc(1'b0, USR, 16'h1fff, 16'h0, VI);
    acc(1'b0, FW, 16'h1fff, 16'h0, PS);
    acc(1'b0, USR, 16'h4000, 16'h0, VI);
    acc(1'b1, SYS, mbag_pkg::CREG_MAP_SEGB, 16'h4000, NO);
    acc(1'b1, SYS, mbag_pkg::CREG_MAP_SEGL, 16'h4010, NO);
    acc(1'b1, USR, 16'h400f, 16'hbeef, PS);
    acc(1'b1, USR, 16'h4010, 16'hbeef, VI);
    acc(1'b1, SYS, mbag_pkg::CREG_MAP_SEGB, 16'h0000, NO);
    acc(1'b0, USR, 16'h0000, 16'h0, VI);
  endtask

  task automatic t_trim;
    acc(1'b1, FW, mbag_pkg::CREG_MAP_NVM, 16'h0003, VI);
    chk({12'h0, nvm_read_trim}, 16'h0008);
    acc(1'b1, SYS, mbag_pkg::CREG_MAP_NVM, 16'h0003, NO);
    chk({12'h0, nvm_read_trim}, 16'h0003);
  endtask

  // ****************************************
  // Verdict and main sequence
  // ****************************************
  task automatic report_and_stop;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // About 35 accesses of two cycles each; generous margin
  initial begin
    repeat (2000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clock);
    #1;
    srst = 1'b0;
    t_defaults();
    t_pointer();
    t_periph();
    t_memory();
    t_trim();
    // Reset in mid-run must bring back every default
    @(posedge clock);
    #1;
    srst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    srst = 1'b0;
    t_defaults();
    report_and_stop();
  end
endmodule
